/* decode_cost_pkg.sv */
// Package: opcode classes, cost constants and carrier structs for the decoder
//
// Contract
// - Each wait state adds one clock per data access of the instruction.
// - 1000100w modrm: transfer to r/m, 2 clocks, 0 or 1 data cycles.
// - 1000101w modrm: transfer from r/m, 2 clocks register, 4 clocks memory.
// - 1100011w reg 000 with immediate: immediate transfer, 2 clocks.
// - 10001110: segment register load, memory form uses six data cycles.
// - 0F then 1011011w: zero extending transfer, 3 or 6 clocks.
// - 11111111 reg 110: stack store, 7 or 9 clocks, 2 or 4 cycles.
// - 10001111 reg 000: stack load, 7 or 9 clocks, 2 or 4 cycles.
// - 1000011w modrm: operand swap, 3 or 5 clocks, 0 or 2 cycles.
// - 1110010w port: fixed port input, 6 or 26 clocks, one cycle.
// - 1110011w port: fixed port output, 4 or 24 clocks, one cycle.
// - 10001101 modrm: effective address load, 2 clocks, no data cycle.
// - C5 and C4: far pointer loads, 26 clocks, six data cycles.
// - 0F B4 and 0F B5: far pointer loads, 29 clocks, six cycles.
// - 0F B2: far pointer load to stack segment, 26 clocks, six cycles.
// - 0F 06: task switched flag clear, 6 clocks.
// - 11111010: interrupt enable clear, cost 6 or 8 by note condition.
// - Interrupt enable set executes in 8 clocks.
// - 10011110: flags from high accumulator byte, 3 clocks.
// - 000100dw: add with carry register to register, 2 clocks, no cycles.
// - 0001000w: add with carry into memory, 7 clocks, two data cycles.
// - 100000sw reg 010: add with carry immediate, 2 or 7, 0 or 2.
// - 100000sw reg 000: add immediate, 2 or 7 clocks, 0 or 2.
// - 1111111w reg 000: increment, 2 or 6 clocks, 0 or 2 cycles.
// - Smaller count for register operand, larger for memory operand.
// - Two register address components add one clock.
// - Misaligned operand adds 2 for read or write, 4 for both.
package decode_cost_pkg;

  typedef enum logic [4:0] {
    OP_NONE, XFER_TO_RM, XFER_FROM_RM, XFER_IMM, SEG_LOAD, ZX_XFER,
    STACK_STORE, STACK_LOAD, SWAP_RM, PORT_IN, PORT_OUT, EA_LOAD,
    FP_DATA, FP_EXTRA, FP_THIRD, FP_FOURTH, FP_STACK, TS_CLEAR,
    IE_CLEAR, IE_SET, FLAGS_AH, ADC_RR, ADC_RM, ADC_IMM, ADD_IMM, INC_RM
  } op_class_t;

  // Instruction bytes as handed over by the prefetch queue
  typedef struct packed {
    logic       two_byte;
    logic [7:0] opcode;
    logic [7:0] modrm;
  } insn_t;

  // Per-instruction execution conditions from the bus unit
  typedef struct packed {
    logic [3:0] wait_states;
    logic       two_reg_ea;
    logic       misaligned;
    logic       note_cond;
  } exec_cond_t;

  // Table entry: clock and data cycle pairs, register then memory
  typedef struct packed {
    op_class_t  cls;
    logic [4:0] clk_reg;
    logic [4:0] clk_mem;
    logic [2:0] dc_reg;
    logic [2:0] dc_mem;
    logic       uses_ea;
    logic       rmw;
  } entry_t;

  // Decoded cost handed to execution
  typedef struct packed {
    logic       valid;
    logic       known;
    logic       wide;
    logic       mem_op;
    op_class_t  cls;
    logic [8:0] clocks;
    logic [2:0] data_cycles;
  } cost_t;

  localparam logic [7:0] ESC_BYTE   = 8'h0f;
  localparam logic [1:0] MOD_REG    = 2'h3;
  localparam logic [4:0] EXTRA_EA   = 5'h01;
  localparam logic [4:0] MIS_ONE    = 5'h02;
  localparam logic [4:0] MIS_BOTH   = 5'h04;
  localparam logic [4:0] CLK_SEGM   = 5'h16;
  localparam logic [4:0] CLK_SEGR   = 5'h1d;
  localparam logic [4:0] CLK_FAR    = 5'h1a;
  localparam logic [4:0] CLK_FARX   = 5'h1d;
  localparam logic [4:0] CLK_INF    = 5'h06;
  localparam logic [4:0] CLK_INS    = 5'h1a;
  localparam logic [4:0] CLK_OUTF   = 5'h04;
  localparam logic [4:0] CLK_OUTS   = 5'h18;
  localparam logic [4:0] CLK_IECF   = 5'h06;
  localparam logic [4:0] CLK_IECS   = 5'h08;
  localparam logic [4:0] CLK_IES    = 5'h08;

endpackage

/* exec_sink.sv */
// Execution unit model that takes each decoded cost as it appears
`timescale 1ns/10ps
`default_nettype none

module exec_sink (
  // Clock, reset and enable
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic                   ce,
  // Result from the decoder
  input  wire logic                   out_valid,
  input  wire decode_cost_pkg::cost_t cost,
  // Captured result, one cycle per fresh result
  output logic                        got,
  output decode_cost_pkg::cost_t      got_cost
);
  logic ce_reg;

  // A result is fresh only after an edge that ran with ce high
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ce_reg   <= 1'b0;
      got      <= 1'b0;
      got_cost <= '0;
    end else begin
      ce_reg <= ce;
      got    <= ce_reg & out_valid;
      // Stale capture is inverted so a missed pulse never looks right
      got_cost <= (ce_reg & out_valid) ? cost : ~cost;
    end
  end
endmodule
`default_nettype wire

/* opcode_decode_cycle_cost.sv */
// Opcode decoder producing total clock count and data bus cycle count
`timescale 1ns/10ps
`default_nettype none

module opcode_decode_cycle_cost (
  // Clock, reset and enable
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  // Instruction from prefetch queue
  input  wire logic                        in_valid,
  input  wire decode_cost_pkg::insn_t      insn,
  input  wire decode_cost_pkg::exec_cond_t cond,
  // Cost to execution and bus units
  output logic                             out_valid,
  output decode_cost_pkg::cost_t           cost
);

  typedef struct packed {
    decode_cost_pkg::cost_t cost;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Builds one table entry
  function automatic decode_cost_pkg::entry_t ent(
    input decode_cost_pkg::op_class_t c,
    input logic [4:0] cr,
    input logic [4:0] cm,
    input logic [2:0] dr,
    input logic [2:0] dm,
    input logic       ea,
    input logic       rw
  );
    decode_cost_pkg::entry_t e;
    e.cls     = c;
    e.clk_reg = cr;
    e.clk_mem = cm;
    e.dc_reg  = dr;
    e.dc_mem  = dm;
    e.uses_ea = ea;
    e.rmw     = rw;
    return e;
  endfunction

  // Opcode table lookup; unknown patterns give class OP_NONE
  function automatic decode_cost_pkg::entry_t decode(
    input decode_cost_pkg::insn_t i,
    input logic                   nc
  );
    decode_cost_pkg::entry_t e;
    logic [2:0] rf;
    e  = ent(decode_cost_pkg::OP_NONE, 5'h00, 5'h00, 3'h0, 3'h0, 1'b0, 1'b0);
    rf = i.modrm[5:3];
    if (i.two_byte) begin
      // Second byte after the escape
      casez (i.opcode)
        8'b1011011?: e = ent(decode_cost_pkg::ZX_XFER, 5'h03, 5'h06,
                             3'h0, 3'h1, 1'b1, 1'b0);
        8'hb4: e = ent(decode_cost_pkg::FP_THIRD, decode_cost_pkg::CLK_FARX,
                       decode_cost_pkg::CLK_FARX, 3'h6, 3'h6, 1'b1, 1'b0);
        8'hb5: e = ent(decode_cost_pkg::FP_FOURTH, decode_cost_pkg::CLK_FARX,
                       decode_cost_pkg::CLK_FARX, 3'h6, 3'h6, 1'b1, 1'b0);
        8'hb2: e = ent(decode_cost_pkg::FP_STACK, decode_cost_pkg::CLK_FAR,
                       decode_cost_pkg::CLK_FAR, 3'h6, 3'h6, 1'b1, 1'b0);
        8'h06: e = ent(decode_cost_pkg::TS_CLEAR, 5'h06, 5'h06,
                       3'h0, 3'h0, 1'b0, 1'b0);
        default: e.cls = decode_cost_pkg::OP_NONE;
      endcase
    end else begin
      casez (i.opcode)
        8'b1000100?: e = ent(decode_cost_pkg::XFER_TO_RM, 5'h02, 5'h02,
                             3'h0, 3'h1, 1'b1, 1'b0);
        8'b1000101?: e = ent(decode_cost_pkg::XFER_FROM_RM, 5'h02, 5'h04,
                             3'h0, 3'h1, 1'b1, 1'b0);
        8'b1100011?: begin
          if (rf == 3'h0) begin
            e = ent(decode_cost_pkg::XFER_IMM, 5'h02, 5'h02,
                    3'h0, 3'h1, 1'b1, 1'b0);
          end
        end
        8'h8e: e = ent(decode_cost_pkg::SEG_LOAD, decode_cost_pkg::CLK_SEGM,
                       decode_cost_pkg::CLK_SEGR, 3'h0, 3'h6, 1'b1, 1'b0);
        8'hff: begin
          if (rf == 3'h6) begin
            e = ent(decode_cost_pkg::STACK_STORE, 5'h07, 5'h09,
                    3'h2, 3'h4, 1'b1, 1'b1);
          end else if (rf == 3'h0) begin
            e = ent(decode_cost_pkg::INC_RM, 5'h02, 5'h06,
                    3'h0, 3'h2, 1'b1, 1'b1);
          end
        end
        8'hfe: begin
          if (rf == 3'h0) begin
            e = ent(decode_cost_pkg::INC_RM, 5'h02, 5'h06,
                    3'h0, 3'h2, 1'b1, 1'b1);
          end
        end
        8'h8f: begin
          if (rf == 3'h0) begin
            e = ent(decode_cost_pkg::STACK_LOAD, 5'h07, 5'h09,
                    3'h2, 3'h4, 1'b1, 1'b1);
          end
        end
        8'b1000011?: e = ent(decode_cost_pkg::SWAP_RM, 5'h03, 5'h05,
                             3'h0, 3'h2, 1'b1, 1'b1);
        8'b1110010?: begin
          // Note condition picks the slower count
          e = ent(decode_cost_pkg::PORT_IN,
                  nc ? decode_cost_pkg::CLK_INS : decode_cost_pkg::CLK_INF,
                  nc ? decode_cost_pkg::CLK_INS : decode_cost_pkg::CLK_INF,
                  3'h1, 3'h1, 1'b0, 1'b0);
        end
        8'b1110011?: begin
          e = ent(decode_cost_pkg::PORT_OUT,
                  nc ? decode_cost_pkg::CLK_OUTS : decode_cost_pkg::CLK_OUTF,
                  nc ? decode_cost_pkg::CLK_OUTS : decode_cost_pkg::CLK_OUTF,
                  3'h1, 3'h1, 1'b0, 1'b0);
        end
        8'h8d: e = ent(decode_cost_pkg::EA_LOAD, 5'h02, 5'h02,
                       3'h0, 3'h0, 1'b1, 1'b0);
        8'hc5: e = ent(decode_cost_pkg::FP_DATA, decode_cost_pkg::CLK_FAR,
                       decode_cost_pkg::CLK_FAR, 3'h6, 3'h6, 1'b1, 1'b0);
        8'hc4: e = ent(decode_cost_pkg::FP_EXTRA, decode_cost_pkg::CLK_FAR,
                       decode_cost_pkg::CLK_FAR, 3'h6, 3'h6, 1'b1, 1'b0);
        8'hfa: begin
          e = ent(decode_cost_pkg::IE_CLEAR,
                  nc ? decode_cost_pkg::CLK_IECS : decode_cost_pkg::CLK_IECF,
                  nc ? decode_cost_pkg::CLK_IECS : decode_cost_pkg::CLK_IECF,
                  3'h0, 3'h0, 1'b0, 1'b0);
        end
        8'hfb: e = ent(decode_cost_pkg::IE_SET, decode_cost_pkg::CLK_IES,
                       decode_cost_pkg::CLK_IES, 3'h0, 3'h0, 1'b0, 1'b0);
        8'h9e: e = ent(decode_cost_pkg::FLAGS_AH, 5'h03, 5'h03,
                       3'h0, 3'h0, 1'b0, 1'b0);
        8'b0001000?: begin
          // Register forms cost 2, memory destination is read and write
          e = ent(decode_cost_pkg::ADC_RM, 5'h02, 5'h07,
                  3'h0, 3'h2, 1'b1, 1'b1);
        end
        8'b0001001?: e = ent(decode_cost_pkg::ADC_RR, 5'h02, 5'h02,
                             3'h0, 3'h0, 1'b0, 1'b0);
        8'b100000??: begin
          if (rf == 3'h2) begin
            e = ent(decode_cost_pkg::ADC_IMM, 5'h02, 5'h07,
                    3'h0, 3'h2, 1'b1, 1'b1);
          end else if (rf == 3'h0) begin
            e = ent(decode_cost_pkg::ADD_IMM, 5'h02, 5'h07,
                    3'h0, 3'h2, 1'b1, 1'b1);
          end
        end
        default: e.cls = decode_cost_pkg::OP_NONE;
      endcase
    end
    return e;
  endfunction

  // Wait clocks: one per wait state on every data access
  function automatic logic [6:0] wait_cost(
    input logic [3:0] ws,
    input logic [2:0] dc
  );
    return 7'(ws * dc);
  endfunction

  decode_cost_pkg::entry_t ent_c;
  logic                    mem_c;
  logic [2:0]              dc_c;
  logic [4:0]              base_c;
  logic [4:0]              ea_c;
  logic [4:0]              mis_c;

  // Register versus memory selection and per-instruction adders
  always_comb begin
    ent_c  = decode(insn, cond.note_cond);
    // Mod 11 selects a register operand; other mods address memory only for entries with an r/m operand
    mem_c  = ent_c.uses_ea && (insn.modrm[7:6] != decode_cost_pkg::MOD_REG);
    base_c = mem_c ? ent_c.clk_mem : ent_c.clk_reg;
    dc_c   = mem_c ? ent_c.dc_mem : ent_c.dc_reg;
    ea_c   = (mem_c && cond.two_reg_ea) ? decode_cost_pkg::EXTRA_EA : 5'h00;
    mis_c  = 5'h00;
    // Read-modify-write forms touch the operand twice
    if (cond.misaligned && (dc_c != 3'h0)) begin
      mis_c = ent_c.rmw ? decode_cost_pkg::MIS_BOTH : decode_cost_pkg::MIS_ONE;
    end
  end

  // Next state: a new cost per accepted instruction; with ce high and no request only valid clears
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.cost.valid = in_valid;
      if (in_valid) begin
        state_next.cost.known       = (ent_c.cls != decode_cost_pkg::OP_NONE);
        state_next.cost.cls         = ent_c.cls;
        state_next.cost.mem_op      = mem_c;
        // Byte form has w clear; zero extend source is always narrow or wide
        state_next.cost.wide        = insn.opcode[0];
        state_next.cost.data_cycles = dc_c;
        state_next.cost.clocks      = 9'(base_c) + 9'(ea_c) + 9'(mis_c)
                                      + 9'(wait_cost(cond.wait_states, dc_c));
      end
    end
  end

  // State register; ce low freezes everything
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign out_valid = state_reg.cost.valid;
  assign cost      = state_reg.cost;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    ce && in_valid;
  endsequence

  sequence s_clean;
    cond.wait_states == 4'h0 && !cond.two_reg_ea && !cond.misaligned;
  endsequence

  property p_wait;
    s_take ##0 (insn.two_byte == 1'b0 && insn.opcode == 8'he4 && !cond.note_cond
                && !cond.misaligned)
    |=> cost.clocks == 9'd6 + 9'($past(cond.wait_states));
  endproperty
  a_wait: assert property (p_wait) else $error("Wait clocks wrong");

  property p_to_rm;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h44)
    |=> cost.clocks == 9'd2 && cost.data_cycles == ($past(insn.modrm[7:6]) == 2'h3 ? 3'd0 : 3'd1);
  endproperty
  a_to_rm: assert property (p_to_rm) else $error("Transfer to r/m cost wrong");

  property p_from_rm;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h45)
    |=> cost.clocks == ($past(insn.modrm[7:6]) == 2'h3 ? 9'd2 : 9'd4);
  endproperty
  a_from_rm: assert property (p_from_rm) else $error("Transfer from r/m cost wrong");

  property p_stack;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode == 8'hff && insn.modrm[7:3] == 5'h06)
    |=> cost.clocks == 9'd9 && cost.data_cycles == 3'd4 && cost.known;
  endproperty
  a_stack: assert property (p_stack) else $error("Stack store cost wrong");

  property p_port;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h73 && cond.note_cond)
    |=> cost.clocks == 9'd24 && cost.data_cycles == 3'd1;
  endproperty
  a_port: assert property (p_port) else $error("Port output cost wrong");

  property p_far;
    s_take ##0 s_clean ##0 (insn.two_byte && insn.opcode == 8'hb5)
    |=> cost.clocks == 9'd29 && cost.data_cycles == 3'd6;
  endproperty
  a_far: assert property (p_far) else $error("Far pointer cost wrong");

  property p_ea;
    s_take ##0 (!insn.two_byte && insn.opcode == 8'h8d && insn.modrm[7:6] != 2'h3
                && cond.two_reg_ea)
    |=> cost.clocks == 9'd3 && cost.data_cycles == 3'd0;
  endproperty
  a_ea: assert property (p_ea) else $error("Address component clock missing");

  property p_mis;
    s_take ##0 (!insn.two_byte && insn.opcode == 8'hfe && insn.modrm[7:6] != 2'h3
                && insn.modrm[5:3] == 3'h0 && cond.misaligned && !cond.two_reg_ea)
    |=> cost.clocks == 9'd10 + 9'({$past(cond.wait_states), 1'b0});
  endproperty
  a_mis: assert property (p_mis) else $error("Misaligned increment cost wrong");

  property p_idle;
    ce && !in_valid |=> !out_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("Valid without request");

  property p_hold;
    !ce |=> $stable(cost);
  endproperty
  a_hold: assert property (p_hold) else $error("State moved with enable low");

  // Base costs per class with no adders in play
  property p_imm;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h63 && insn.modrm[5:3] == 3'h0)
    |=> cost.clocks == 9'd2 && cost.known;
  endproperty
  a_imm: assert property (p_imm) else $error("Immediate transfer cost wrong");

  property p_seg;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode == 8'h8e && insn.modrm[7:6] != 2'h3)
    |=> cost.clocks == 9'd29 && cost.data_cycles == 3'd6;
  endproperty
  a_seg: assert property (p_seg) else $error("Segment load cost wrong");

  property p_zx;
    s_take ##0 s_clean ##0 (insn.two_byte && insn.opcode[7:1] == 7'h5b)
    |=> cost.clocks == ($past(insn.modrm[7:6]) == 2'h3 ? 9'd3 : 9'd6);
  endproperty
  a_zx: assert property (p_zx) else $error("Zero extend cost wrong");

  property p_pop;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode == 8'h8f && insn.modrm[5:3] == 3'h0)
    |=> cost.clocks == ($past(insn.modrm[7:6]) == 2'h3 ? 9'd7 : 9'd9);
  endproperty
  a_pop: assert property (p_pop) else $error("Stack load cost wrong");

  // Register form: no data access, so no adder can apply
  property p_swap;
    s_take ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h43 && insn.modrm[7:6] == 2'h3)
    |=> cost.clocks == 9'd3 && cost.data_cycles == 3'd0;
  endproperty
  a_swap: assert property (p_swap) else $error("Swap register cost wrong");

  property p_farp;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h62)
    |=> cost.clocks == 9'd26 && cost.data_cycles == 3'd6;
  endproperty
  a_farp: assert property (p_farp) else $error("Far pointer load cost wrong");

  property p_ts;
    s_take ##0 (insn.two_byte && insn.opcode == 8'h06)
    |=> cost.clocks == 9'd6 && cost.data_cycles == 3'd0;
  endproperty
  a_ts: assert property (p_ts) else $error("Task switched clear cost wrong");

  property p_iec;
    s_take ##0 (!insn.two_byte && insn.opcode == 8'hfa)
    |=> cost.clocks == ($past(cond.note_cond) ? 9'd8 : 9'd6);
  endproperty
  a_iec: assert property (p_iec) else $error("Interrupt clear cost wrong");

  property p_flags;
    s_take ##0 (!insn.two_byte && insn.opcode == 8'h9e)
    |=> cost.clocks == 9'd3 && cost.data_cycles == 3'd0;
  endproperty
  a_flags: assert property (p_flags) else $error("Flags load cost wrong");

  property p_adc_mem;
    s_take ##0 s_clean ##0 (!insn.two_byte && insn.opcode[7:1] == 7'h08 && insn.modrm[7:6] != 2'h3)
    |=> cost.clocks == 9'd7 && cost.data_cycles == 3'd2;
  endproperty
  a_adc_mem: assert property (p_adc_mem) else $error("Carry add to memory cost wrong");

endmodule

`default_nettype wire

/* opcode_decode_cycle_cost_tb.sv */
// Self-checking bench for the opcode decoder and cycle cost logic
`timescale 1ns/10ps
`default_nettype none

module opcode_decode_cycle_cost_tb;
  logic                        mclk;
  logic                        rst_b;
  logic                        ce;
  logic                        in_valid;
  decode_cost_pkg::insn_t      insn;
  decode_cost_pkg::exec_cond_t cond;
  logic                        out_valid;
  decode_cost_pkg::cost_t      cost;
  logic                        got;
  decode_cost_pkg::cost_t      got_cost;
  decode_cost_pkg::cost_t      exp_q[$];
  decode_cost_pkg::cost_t      ex;
  decode_cost_pkg::cost_t      held;
  logic                        ce_d;
  logic                        rst_d;
  logic                        last_fx;
  int                          bad_count = 0;
  int                          cmp_count = 0;
  // {two_byte, opcode, reg field forced, reg value}; last two are unknown opcodes
  logic [12:0]                 tbl [39] = '{13'h0880, 13'h0890, 13'h08a0, 13'h08b0, 13'h0c68, 13'h0c78,
    13'h08e0, 13'h1b60, 13'h1b70, 13'h0ffe, 13'h08f8, 13'h0860, 13'h0870, 13'h0e40, 13'h0e50, 13'h0e60,
    13'h0e70, 13'h08d0, 13'h0c50, 13'h0c40, 13'h1b40, 13'h1b50, 13'h1b20, 13'h1060, 13'h0fa0, 13'h0fb0,
    13'h09e0, 13'h0100, 13'h0110, 13'h0120, 13'h0130, 13'h080a, 13'h083a, 13'h0818, 13'h0828, 13'h0fe8,
    13'h0ff8, 13'h0900, 13'h1a20};

  opcode_decode_cycle_cost dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .in_valid(in_valid), .insn(insn),
    .cond(cond), .out_valid(out_valid), .cost(cost));
  exec_sink sink_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .out_valid(out_valid), .cost(cost), .got(got),
    .got_cost(got_cost));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Expected cost; e = {class, clk reg, clk mem, dc reg, dc mem, rmw, no memory form}
  function automatic decode_cost_pkg::cost_t exp_of(decode_cost_pkg::insn_t i, decode_cost_pkg::exec_cond_t c);
    decode_cost_pkg::cost_t r;
    logic [22:0] e;
    logic [4:0]  cr;
    logic [4:0]  cm;
    logic [2:0]  dc;
    logic        mem;
    logic        n;
    n = c.note_cond;
    casez ({i.two_byte, i.opcode, i.modrm[5:3]})
      12'b0_1000100?_???: e = {decode_cost_pkg::XFER_TO_RM, 5'h02, 5'h02, 3'h0, 3'h1, 2'h0};
      12'b0_1000101?_???: e = {decode_cost_pkg::XFER_FROM_RM, 5'h02, 5'h04, 3'h0, 3'h1, 2'h0};
      12'b01100011?000: e = {decode_cost_pkg::XFER_IMM, 5'h02, 5'h02, 3'h0, 3'h1, 2'h0};
      12'b0_10001110_???: e = {decode_cost_pkg::SEG_LOAD, 5'h16, 5'h1d, 3'h0, 3'h6, 2'h0};
      12'b1_1011011?_???: e = {decode_cost_pkg::ZX_XFER, 5'h03, 5'h06, 3'h0, 3'h1, 2'h0};
      12'b011111111110: e = {decode_cost_pkg::STACK_STORE, 5'h07, 5'h09, 3'h2, 3'h4, 2'h2};
      12'b010001111000: e = {decode_cost_pkg::STACK_LOAD, 5'h07, 5'h09, 3'h2, 3'h4, 2'h2};
      12'b0_1000011?_???: e = {decode_cost_pkg::SWAP_RM, 5'h03, 5'h05, 3'h0, 3'h2, 2'h2};
      12'b0_1110010?_???: e = {decode_cost_pkg::PORT_IN, {2{n ? 5'h1a : 5'h06}}, 3'h1, 3'h1, 2'h1};
      12'b0_1110011?_???: e = {decode_cost_pkg::PORT_OUT, {2{n ? 5'h18 : 5'h04}}, 3'h1, 3'h1, 2'h1};
      12'b0_10001101_???: e = {decode_cost_pkg::EA_LOAD, 5'h02, 5'h02, 3'h0, 3'h0, 2'h0};
      12'b0_11000101_???: e = {decode_cost_pkg::FP_DATA, 5'h1a, 5'h1a, 3'h6, 3'h6, 2'h0};
      12'b0_11000100_???: e = {decode_cost_pkg::FP_EXTRA, 5'h1a, 5'h1a, 3'h6, 3'h6, 2'h0};
      12'b1_10110100_???: e = {decode_cost_pkg::FP_THIRD, 5'h1d, 5'h1d, 3'h6, 3'h6, 2'h0};
      12'b1_10110101_???: e = {decode_cost_pkg::FP_FOURTH, 5'h1d, 5'h1d, 3'h6, 3'h6, 2'h0};
      12'b1_10110010_???: e = {decode_cost_pkg::FP_STACK, 5'h1a, 5'h1a, 3'h6, 3'h6, 2'h0};
      12'b1_00000110_???: e = {decode_cost_pkg::TS_CLEAR, 5'h06, 5'h06, 3'h0, 3'h0, 2'h1};
      12'b0_11111010_???: e = {decode_cost_pkg::IE_CLEAR, {2{n ? 5'h08 : 5'h06}}, 3'h0, 3'h0, 2'h1};
      12'b0_11111011_???: e = {decode_cost_pkg::IE_SET, 5'h08, 5'h08, 3'h0, 3'h0, 2'h1};
      12'b0_10011110_???: e = {decode_cost_pkg::FLAGS_AH, 5'h03, 5'h03, 3'h0, 3'h0, 2'h1};
      12'b0_0001001?_???: e = {decode_cost_pkg::ADC_RR, 5'h02, 5'h02, 3'h0, 3'h0, 2'h1};
      12'b0_0001000?_???: e = {decode_cost_pkg::ADC_RM, 5'h02, 5'h07, 3'h0, 3'h2, 2'h2};
      12'b0100000??010: e = {decode_cost_pkg::ADC_IMM, 5'h02, 5'h07, 3'h0, 3'h2, 2'h2};
      12'b0100000??000: e = {decode_cost_pkg::ADD_IMM, 5'h02, 5'h07, 3'h0, 3'h2, 2'h2};
      12'b01111111?000: e = {decode_cost_pkg::INC_RM, 5'h02, 5'h06, 3'h0, 3'h2, 2'h2};
      default:            e = {decode_cost_pkg::OP_NONE, 16'h0000, 2'h1};
    endcase
    last_fx = e[0];
    mem = i.modrm[7:6] != decode_cost_pkg::MOD_REG;
    cr = e[17:13];
    cm = e[12:8];
    dc = mem ? e[4:2] : e[7:5];
    r = '0;
    r.valid = 1'b1;
    r.cls = decode_cost_pkg::op_class_t'(e[22:18]);
    r.known = e[22:18] != 5'h00;
    r.wide = i.opcode[0];
    r.mem_op = mem & ~e[0];
    r.data_cycles = dc;
    r.clocks = 9'(mem ? cm : cr) + 9'(mem & c.two_reg_ea & ~e[0])
      + 9'((c.misaligned && dc != 3'h0) ? (e[1] ? 5'h04 : 5'h02) : 5'h00)
      + 9'(c.wait_states) * 9'(dc);
    return r;
  endfunction

  // Presents one request at the falling edge and notes its expected cost
  task automatic drive(input logic [12:0] t, input logic [1:0] md, input logic ce_v, input logic iv,
                       input logic cl);
    decode_cost_pkg::insn_t      ins;
    decode_cost_pkg::exec_cond_t cnd;
    decode_cost_pkg::cost_t      exq;
    @(negedge mclk);
    ins.two_byte = t[12];
    ins.opcode = t[11:4];
    ins.modrm = 8'($urandom);
    ins.modrm[7:6] = md;
    if (t[3]) ins.modrm[5:3] = t[2:0];
    cnd = 8'($urandom);
    // Clean requests keep only the note condition random, so base costs show bare
    if (cl) begin
      cnd.wait_states = 4'h0;
      cnd.two_reg_ea = 1'b0;
      cnd.misaligned = 1'b0;
    end
    exq = exp_of(ins, cnd);
    // Entries whose cost ignores the addressing form get no two-register adder
    if (last_fx) cnd.two_reg_ea = 1'b0;
    exq = exp_of(ins, cnd);
    ce = ce_v;
    in_valid = iv;
    insn = ins;
    cond = cnd;
    if (ce_v && iv) exp_q.push_back(exq);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Enable and reset as seen at each rising edge
  always @(posedge mclk) begin
    ce_d <= ce;
    rst_d <= rst_b;
  end

  // Checks each fresh result against the oldest note, and holding while ce is low
  always @(negedge mclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected result", 1, 0);
      end else begin
        ex = exp_q.pop_front();
        chk("valid", got_cost.valid, 1);
        chk("known", got_cost.known, ex.known);
        chk("class", got_cost.cls, ex.cls);
        chk("clocks", got_cost.clocks, ex.clocks);
        chk("data cycles", got_cost.data_cycles, ex.data_cycles);
        chk("memory operand", got_cost.mem_op, ex.mem_op);
        if (ex.known) chk("wide", got_cost.wide, ex.wide);
      end
    end
    if (rst_d === 1'b1 && ce_d === 1'b0) chk("held cost", {out_valid, cost}, {held.valid, held});
    held = cost;
  end

  // Stimulus
  initial begin
    void'($urandom(32'h60468592));
    ce = 1'b1;
    in_valid = 1'b0;
    insn = '0;
    cond = '0;
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    chk("reset outputs", {out_valid, cost}, 0);
    // Every entry in all four addressing forms, random then clean conditions, back to back
    for (int i = 0; i < 39; i++) begin
      for (int k = 0; k < 8; k++) drive(tbl[i], 2'(k), 1'b1, 1'b1, k > 3);
    end
    // Random mix with gaps and ce stalls
    repeat (3000) drive(tbl[$urandom_range(38)], 2'($urandom), $urandom_range(3) != 0, $urandom_range(2) != 0,
                        $urandom_range(7) == 0);
    drive(tbl[0], 2'h0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge mclk);
    // Reset in mid-run drops a request presented under it
    in_valid = 1'b1;
    rst_b = 1'b0;
    @(negedge mclk);
    chk("mid-run reset", {out_valid, cost}, 0);
    rst_b = 1'b1;
    in_valid = 1'b0;
    repeat (3) @(negedge mclk);
    chk("results left over", exp_q.size(), 0);
    report_and_stop();
  end

  // Watchdog well past the expected run of some 3300 cycles
  initial begin
    #200us;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
